// File: pkg/akb_pkg.sv
// constants and types shared by the authentication key block
// assumes byte-wide command locations and one 40 MHz clock domain
// Functional notes
// - challenge returns 160-bit keyed SHA-1 digest
// - default key used until one programmed
// - locked device reads out no key byte, unless it is relocked in a digest write-back cycle
// - key replaced only while unlocked
// - access select 0x00 maps flash block
// - class 0x70 maps security block
// - 32 buffer bytes readable at 0x40-0x5f
// - key bytes sit at 0x48-0x57
// - commit only on correct checksum write
// - checksum is 255 minus byte sum
// - device accepts relock after commit
// - commit only when cell voltage sufficient
// - valid challenge sum replaces challenge with digest
package akb_pkg;
   localparam logic [7:0]   AKB_ADDR_CLASS = 8'h3e;
   localparam logic [7:0]   AKB_ADDR_BUF   = 8'h40;
   localparam logic [7:0]   AKB_ADDR_LAST  = 8'h5f;
   localparam logic [7:0]   AKB_ADDR_SUM   = 8'h60;
   localparam logic [7:0]   AKB_ADDR_CTL   = 8'h61;
   localparam logic [4:0]   AKB_KEY_FIRST  = 5'h08;
   localparam logic [4:0]   AKB_KEY_LAST   = 5'h17;
   localparam logic [4:0]   AKB_CHAL_LAST  = 5'h13;
   localparam logic [7:0]   AKB_SEC_CLASS  = 8'h70;
   localparam logic [7:0]   AKB_MODE_FLASH = 8'h00;
   localparam logic [7:0]   AKB_MODE_AUTH  = 8'h01;
   localparam logic [7:0]   AKB_SUM_BASE   = 8'hff;
   localparam logic [127:0] AKB_KEY_DFLT   = 128'h0123456789abcdeffedcba9876543210;
   localparam logic [7:0]   AKB_IPAD       = 8'h36;
   localparam logic [7:0]   AKB_OPAD       = 8'h5c;
   localparam logic [7:0]   AKB_PAD_ONE    = 8'h80;
   localparam logic [63:0]  AKB_MSG_BITS   = 64'h2a0;
   localparam logic [6:0]   AKB_LAST_RND   = 7'h4f;
   localparam logic [159:0] AKB_SHA_IV     =
      160'h67452301efcdab8998badcfe10325476c3d2e1f0;
   localparam logic [31:0]  AKB_K0 = 32'h5a827999;
   localparam logic [31:0]  AKB_K1 = 32'h6ed9eba1;
   localparam logic [31:0]  AKB_K2 = 32'h8f1bbcdc;
   localparam logic [31:0]  AKB_K3 = 32'hca62c1d6;

   typedef enum logic [3:0] {
      AKB_DG_IDLE  = 4'h1,
      AKB_DG_LOAD  = 4'h2,
      AKB_DG_ROUND = 4'h4,
      AKB_DG_ADD   = 4'h8
   } akb_dg_st_t;
endpackage

// File: core/akb_digest.sv
// iterative keyed sha-1 engine: four compressions, one round per clock
// assumes key and challenge stay stable while busy is high
`timescale 1ns/1ps
module akb_digest (
   input  wire logic         core_clk,
   input  wire logic         srst,
   input  wire logic         start,
   input  wire logic [127:0] key,
   input  wire logic [159:0] chal,
   output logic              busy,
   output logic              done,
   output logic [159:0]      digest
);
   akb_pkg::akb_dg_st_t state_q;
   logic [1:0]   phase_q;
   logic [6:0]   rnd_q;
   logic [159:0] h_q;
   logic [159:0] ih_q;
   logic [159:0] v_q;
   logic [511:0] w_q;
   logic [31:0]  a, b, c, d, e, f, k, tmp, wn;
   logic [159:0] h_d;

   // padded 64-byte block for each compression phase
   function automatic logic [511:0] blk(input logic [1:0] ph, input logic [127:0] kk,
                                        input logic [159:0] m, input logic [159:0] ih);
      case (ph)
         2'h0: blk = {kk ^ {16{akb_pkg::AKB_IPAD}}, {48{akb_pkg::AKB_IPAD}}};
         2'h1: blk = {m, akb_pkg::AKB_PAD_ONE, 280'h0, akb_pkg::AKB_MSG_BITS};
         2'h2: blk = {kk ^ {16{akb_pkg::AKB_OPAD}}, {48{akb_pkg::AKB_OPAD}}};
         default: blk = {ih, akb_pkg::AKB_PAD_ONE, 280'h0, akb_pkg::AKB_MSG_BITS};
      endcase
   endfunction

   always_comb begin
      {a, b, c, d, e} = v_q;
      if (rnd_q < 7'h14) begin
         f = (b & c) | (~b & d);
         k = akb_pkg::AKB_K0;
      end else if (rnd_q < 7'h28) begin
         f = b ^ c ^ d;
         k = akb_pkg::AKB_K1;
      end else if (rnd_q < 7'h3c) begin
         f = (b & c) | (b & d) | (c & d);
         k = akb_pkg::AKB_K2;
      end else begin
         f = b ^ c ^ d;
         k = akb_pkg::AKB_K3;
      end
      tmp = {a[26:0], a[31:27]} + f + e + k + w_q[511:480];
      wn  = w_q[511:480] ^ w_q[447:416] ^ w_q[255:224] ^ w_q[95:64];
   end

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_add
         assign h_d[gi*32 +: 32] = h_q[gi*32 +: 32] + v_q[gi*32 +: 32];
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q <= akb_pkg::AKB_DG_IDLE;
         phase_q <= 2'h0;
         rnd_q   <= 7'h0;
         h_q     <= 160'h0;
         ih_q    <= 160'h0;
         v_q     <= 160'h0;
         w_q     <= 512'h0;
         done    <= 1'b0;
         digest  <= 160'h0;
      end else begin
         done <= 1'b0;
         unique case (state_q)
            akb_pkg::AKB_DG_IDLE: if (start) begin
               phase_q <= 2'h0;
               h_q     <= akb_pkg::AKB_SHA_IV;
               state_q <= akb_pkg::AKB_DG_LOAD;
            end
            akb_pkg::AKB_DG_LOAD: begin
               w_q     <= blk(phase_q, key, chal, ih_q);
               v_q     <= h_q;
               rnd_q   <= 7'h0;
               state_q <= akb_pkg::AKB_DG_ROUND;
            end
            akb_pkg::AKB_DG_ROUND: begin
               v_q   <= {tmp, a, {b[1:0], b[31:2]}, c, d};
               w_q   <= {w_q[479:0], wn[30:0], wn[31]};
               rnd_q <= rnd_q + 7'h1;
               if (rnd_q == akb_pkg::AKB_LAST_RND) state_q <= akb_pkg::AKB_DG_ADD;
            end
            akb_pkg::AKB_DG_ADD: begin
               phase_q <= phase_q + 2'h1;
               state_q <= akb_pkg::AKB_DG_LOAD;
               if (phase_q == 2'h1) begin
                  ih_q <= h_d;
                  h_q  <= akb_pkg::AKB_SHA_IV;
               end else begin
                  h_q <= h_d;
               end
               if (phase_q == 2'h3) begin
                  digest  <= h_d;
                  done    <= 1'b1;
                  state_q <= akb_pkg::AKB_DG_IDLE;
               end
            end
         endcase
      end
   end

   assign busy = (state_q != akb_pkg::AKB_DG_IDLE);

   digest_bound_a: assert property (@(posedge core_clk) disable iff (srst)
      (start && !busy) |-> ##[329:329] done)
      else $error("digest not finished in time");
endmodule

// File: core/akb_top.sv
// authentication and key storage block behind byte-wide command locations
// assumes host commands are synchronous single-cycle strobes; lock state
// changes come from the security logic as pulses
`timescale 1ns/1ps
module akb_top (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic [7:0]  cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   output logic [7:0]       cmd_rdata,
   input  wire logic [15:0] cell_mv,
   input  wire logic [15:0] flash_ok_mv,
   input  wire logic        unlock_req,
   input  wire logic        lock_req,
   output logic             unlocked_state,
   output logic             auth_busy,
   output logic             flash_commit
);
   logic [7:0]   buf_q [32];
   logic [7:0]   flash_q [32];
   logic [7:0]   access_q;
   logic [7:0]   class_q;
   logic [7:0]   sum_q;
   logic [127:0] key;
   logic [159:0] chal;
   logic [159:0] digest;
   logic         dg_done;
   logic         dg_start;
   logic         in_buf;
   logic [4:0]   idx;
   logic [7:0]   blk_sum;
   logic [7:0]   chal_sum;
   logic         flash_map;
   logic         sum_wr;

   // 8-bit wrapping sum of buffer bytes 0..last
   function automatic logic [7:0] byte_sum(input logic [7:0] bytes [32],
                                           input logic [4:0] last);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 32; i++) begin
         if (i <= int'(last)) s = s + bytes[i];
      end
      byte_sum = s;
   endfunction

   assign in_buf    = (cmd_addr >= akb_pkg::AKB_ADDR_BUF) && (cmd_addr <= akb_pkg::AKB_ADDR_LAST);
   assign idx       = cmd_addr[4:0];
   assign blk_sum   = akb_pkg::AKB_SUM_BASE - byte_sum(buf_q, 5'h1f);
   assign chal_sum  = akb_pkg::AKB_SUM_BASE - byte_sum(buf_q, akb_pkg::AKB_CHAL_LAST);
   assign flash_map = unlocked_state && (access_q == akb_pkg::AKB_MODE_FLASH)
                      && (class_q == akb_pkg::AKB_SEC_CLASS);
   assign sum_wr    = cmd_wr && (cmd_addr == akb_pkg::AKB_ADDR_SUM);

   genvar gk;
   generate
      for (gk = 0; gk < 16; gk++) begin : g_key
         assign key[127 - gk*8 -: 8] = flash_q[int'(akb_pkg::AKB_KEY_FIRST) + gk];
      end
      for (gk = 0; gk < 20; gk++) begin : g_chal
         assign chal[159 - gk*8 -: 8] = buf_q[gk];
      end
   endgenerate

   // security state: lock wins over unlock in the same cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         unlocked_state <= 1'b0;
      end else if (lock_req) begin
         unlocked_state <= 1'b0;
      end else if (unlock_req) begin
         unlocked_state <= 1'b1;
      end
   end

   // access select and class select
   always_ff @(posedge core_clk) begin
      if (srst) begin
         access_q <= akb_pkg::AKB_MODE_AUTH;
         class_q  <= 8'h00;
      end else if (cmd_wr && cmd_addr == akb_pkg::AKB_ADDR_CTL) begin
         access_q <= cmd_wdata;
      end else if (cmd_wr && cmd_addr == akb_pkg::AKB_ADDR_CLASS) begin
         class_q <= cmd_wdata;
      end
   end

   // challenge start only on a matching sum in authentication mode
   assign dg_start = sum_wr && (access_q == akb_pkg::AKB_MODE_AUTH)
                     && (cmd_wdata == chal_sum) && !auth_busy;

   akb_digest u_digest (
      .core_clk (core_clk),
      .srst     (srst),
      .start    (dg_start),
      .key      (key),
      .chal     (chal),
      .busy     (auth_busy),
      .done     (dg_done),
      .digest   (digest)
   );

   // transfer buffer: host writes, class mapping, digest write-back
   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int i = 0; i < 32; i++) buf_q[i] <= 8'h00;
      end else if (dg_done) begin
         for (int i = 0; i < 20; i++) buf_q[i] <= digest[159 - i*8 -: 8];
      end else if (lock_req) begin
         // relock drops any mapped key copy unless a digest write-back lands in the same cycle
         for (int i = 0; i < 32; i++) buf_q[i] <= 8'h00;
      end else if (cmd_wr && cmd_addr == akb_pkg::AKB_ADDR_CLASS
                   && cmd_wdata == akb_pkg::AKB_SEC_CLASS && unlocked_state
                   && access_q == akb_pkg::AKB_MODE_FLASH) begin
         for (int i = 0; i < 32; i++) buf_q[i] <= flash_q[i];
      end else if (cmd_wr && in_buf && !auth_busy) begin
         buf_q[idx] <= cmd_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sum_q <= 8'h00;
      end else if (sum_wr) begin
         sum_q <= cmd_wdata;
      end
   end

   // flash image; a low cell aborts the commit silently
   always_ff @(posedge core_clk) begin
      if (srst) begin
         flash_commit <= 1'b0;
         for (int i = 0; i < 32; i++) begin
            if (i >= int'(akb_pkg::AKB_KEY_FIRST) && i <= int'(akb_pkg::AKB_KEY_LAST))
               flash_q[i] <= akb_pkg::AKB_KEY_DFLT[127 - (i - 8)*8 -: 8];
            else
               flash_q[i] <= 8'h00;
         end
      end else begin
         flash_commit <= 1'b0;
         if (sum_wr && flash_map && cmd_wdata == blk_sum
             && cell_mv >= flash_ok_mv) begin
            flash_commit <= 1'b1;
            for (int i = 0; i < 32; i++) flash_q[i] <= buf_q[i];
         end
      end
   end

   // read port; key bytes are blanked while locked in flash mode
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmd_rdata <= 8'h00;
      end else if (cmd_rd) begin
         cmd_rdata <= 8'h00;
         if (in_buf) begin
            if (!unlocked_state && access_q == akb_pkg::AKB_MODE_FLASH
                && idx >= akb_pkg::AKB_KEY_FIRST && idx <= akb_pkg::AKB_KEY_LAST)
               cmd_rdata <= 8'h00;
            else
               cmd_rdata <= buf_q[idx];
         end else if (cmd_addr == akb_pkg::AKB_ADDR_SUM) begin
            cmd_rdata <= sum_q;
         end else if (cmd_addr == akb_pkg::AKB_ADDR_CTL) begin
            cmd_rdata <= access_q;
         end else if (cmd_addr == akb_pkg::AKB_ADDR_CLASS) begin
            cmd_rdata <= class_q;
         end
      end
   end

   key_default_a: assert property (@(posedge core_clk)
      srst |=> key == akb_pkg::AKB_KEY_DFLT)
      else $error("key not default after reset");

   locked_read_a: assert property (@(posedge core_clk) disable iff (srst)
      (cmd_rd && !unlocked_state && access_q == akb_pkg::AKB_MODE_FLASH
       && cmd_addr >= 8'h48 && cmd_addr <= 8'h57) |=> cmd_rdata == 8'h00)
      else $error("key byte read while locked");

   commit_unlocked_a: assert property (@(posedge core_clk) disable iff (srst)
      flash_commit |-> $past(unlocked_state))
      else $error("commit while locked");

   commit_sum_a: assert property (@(posedge core_clk) disable iff (srst)
      flash_commit |-> $past(sum_wr) && $past(flash_map)
                       && sum_q == $past(blk_sum))
      else $error("commit without matching checksum");

   commit_volt_a: assert property (@(posedge core_clk) disable iff (srst)
      flash_commit |-> $past(cell_mv) >= $past(flash_ok_mv))
      else $error("commit below voltage threshold");

   bad_sum_a: assert property (@(posedge core_clk) disable iff (srst)
      (sum_wr && cmd_wdata != blk_sum && cmd_wdata != chal_sum)
      |=> !flash_commit && $stable(key) && !$rose(auth_busy))
      else $error("bad checksum had an effect");

   digest_back_a: assert property (@(posedge core_clk) disable iff (srst)
      dg_done |=> buf_q[0] == $past(digest[159:152]) && buf_q[19] == $past(digest[7:0]))
      else $error("digest not written back");

   class_map_a: assert property (@(posedge core_clk) disable iff (srst)
      (cmd_wr && cmd_addr == akb_pkg::AKB_ADDR_CLASS && cmd_wdata == akb_pkg::AKB_SEC_CLASS
       && unlocked_state && access_q == akb_pkg::AKB_MODE_FLASH && !dg_done && !lock_req)
      |=> buf_q[8] == $past(flash_q[8]))
      else $error("security class not mapped");

   relock_a: assert property (@(posedge core_clk) disable iff (srst)
      lock_req |=> !unlocked_state)
      else $error("relock refused");

   lock_wipe_a: assert property (@(posedge core_clk) disable iff (srst)
      (lock_req && !dg_done) |=> buf_q[8] == 8'h00 && buf_q[23] == 8'h00)
      else $error("buffer kept key bytes after lock");

   rdata_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      !cmd_rd |=> $stable(cmd_rdata))
      else $error("read data changed without a read");
endmodule

// File: dv/akb_host_model.sv
// host model: authentication master on the command port, with its own digest
// assumes one bench process calls its tasks, one at a time
`timescale 1ns/1ps
module akb_host_model (
   input  wire logic       core_clk,
   output logic [7:0]      cmd_addr,
   output logic [7:0]      cmd_wdata,
   output logic            cmd_wr,
   output logic            cmd_rd,
   input  wire logic [7:0] cmd_rdata
);
   logic [7:0] shadow [0:31];

   initial begin
      cmd_addr = 8'h00;
      cmd_wdata = 8'h00;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
   end

   // released lines show the inverse, never the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge core_clk);
      cmd_wr <= 1'b0;
      cmd_addr <= ~a;
      cmd_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge core_clk);
      cmd_rd <= 1'b0;
      cmd_addr <= ~a;
      #1;
      d = cmd_rdata;
   endtask

   // first n bytes from 0x40, then complement sum; bump spoils the sum
   task automatic send_blk(input int n, input logic [7:0] bump);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < n; i++) begin
         wr(8'h40 + 8'(i), shadow[i]);
         s = s + shadow[i];
      end
      wr(8'h60, 8'hff - s + bump);
   endtask

   function automatic logic [159:0] sha_blk(input logic [159:0] h, input logic [511:0] m);
      logic [31:0] w [0:79];
      logic [31:0] a, b, c, d, e, f, k, t;
      for (int i = 0; i < 80; i++) begin
         t = (i < 16) ? m[511-32*i -: 32] : w[i-3] ^ w[i-8] ^ w[i-14] ^ w[i-16];
         w[i] = (i < 16) ? t : {t[30:0], t[31]};
      end
      {a, b, c, d, e} = h;
      for (int i = 0; i < 80; i++) begin
         f = (i < 20) ? ((b & c) | (~b & d)) :
             (i >= 40 && i < 60) ? ((b & c) | (b & d) | (c & d)) : (b ^ c ^ d);
         k = (i < 20) ? akb_pkg::AKB_K0 : (i < 40) ? akb_pkg::AKB_K1 :
             (i < 60) ? akb_pkg::AKB_K2 : akb_pkg::AKB_K3;
         t = {a[26:0], a[31:27]} + f + e + k + w[i];
         e = d;
         d = c;
         c = {b[1:0], b[31:2]};
         b = a;
         a = t;
      end
      return {h[159:128] + a, h[127:96] + b, h[95:64] + c, h[63:32] + d, h[31:0] + e};
   endfunction

   // own digest, the reference the device answer must equal
   function automatic logic [159:0] hmac(input logic [127:0] key, input logic [159:0] c);
      logic [511:0] kb;
      logic [159:0] inr;
      kb = {key, 384'h0};
      inr = sha_blk(sha_blk(akb_pkg::AKB_SHA_IV, kb ^ {64{8'h36}}),
                    {c, 8'h80, 280'h0, 64'h2a0});
      return sha_blk(sha_blk(akb_pkg::AKB_SHA_IV, kb ^ {64{8'h5c}}),
                     {inr, 8'h80, 280'h0, 64'h2a0});
   endfunction
endmodule

// File: dv/testbench.sv
// self-checking bench: key change, relock and challenge-response
// assumes the host model drives the command port
`timescale 1ns/1ps
module testbench;
   logic         core_clk, srst, cmd_wr, cmd_rd, unlock_req, lock_req;
   logic         unlocked_state, auth_busy, flash_commit;
   logic [7:0]   cmd_addr, cmd_wdata, cmd_rdata, rb;
   logic [15:0]  cell_mv, flash_ok_mv;
   logic [127:0] nkey;
   int           bad_count, checks_done, cycles, commits, c0;

   akb_top akb_top_i (.core_clk(core_clk), .srst(srst), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
      .cell_mv(cell_mv), .flash_ok_mv(flash_ok_mv), .unlock_req(unlock_req),
      .lock_req(lock_req), .unlocked_state(unlocked_state), .auth_busy(auth_busy),
      .flash_commit(flash_commit));
   akb_host_model akb_host_model_i (.core_clk(core_clk), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));

   always #12.5 core_clk = ~core_clk;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // counts commit cycles, so a stretched pulse shows up
   always @(posedge core_clk) begin
      cycles++;
      if (flash_commit === 1'b1) commits++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic chk(input string n, input logic [159:0] e, input logic [159:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic pulse(input bit lk);
      @(posedge core_clk);
      if (lk) lock_req <= 1'b1;
      else unlock_req <= 1'b1;
      @(posedge core_clk);
      lock_req <= 1'b0;
      unlock_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic run_auth(input logic [127:0] key, input logic [159:0] c);
      logic [159:0] got;
      for (int i = 0; i < 20; i++) akb_host_model_i.shadow[i] = c[159-8*i -: 8];
      akb_host_model_i.send_blk(20, 8'h00);
      repeat (2) @(posedge core_clk);
      #1;
      chk("busy", 1'b1, auth_busy);
      for (int i = 0; i < 600 && auth_busy !== 1'b0; i++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      for (int i = 0; i < 20; i++) begin
         akb_host_model_i.rd(8'h40 + 8'(i), rb);
         got = {got[151:0], rb};
      end
      chk("digest", akb_host_model_i.hmac(key, c), got);
   endtask

   task automatic commit(input logic [7:0] bump, input int exp);
      c0 = commits;
      akb_host_model_i.send_blk(32, bump);
      repeat (4) @(posedge core_clk);
      chk("commits", exp, commits - c0);
   endtask

   initial begin
      core_clk = 1'b0;
      srst = 1'b1;
      unlock_req = 1'b0;
      lock_req = 1'b0;
      cell_mv = 16'h0e10;
      flash_ok_mv = 16'h0af0;
      nkey = 128'hc3a55a3c0ff01e2dd2e1f00c3ca55ac3;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      run_auth(akb_pkg::AKB_KEY_DFLT, 160'h00112233445566778899aabbccddeeff01234567);
      akb_host_model_i.send_blk(20, 8'h01);
      repeat (3) @(posedge core_clk);
      #1;
      chk("busy on bad sum", 1'b0, auth_busy);
      akb_host_model_i.wr(8'h61, 8'h00);
      akb_host_model_i.wr(8'h3e, 8'h70);
      akb_host_model_i.rd(8'h48, rb);
      chk("locked key byte", 8'h00, rb);
      akb_host_model_i.rd(8'h10, rb);
      chk("unmapped", 8'h00, rb);
      pulse(1'b0);
      chk("unlocked", 1'b1, unlocked_state);
      akb_host_model_i.wr(8'h61, 8'h00);
      akb_host_model_i.wr(8'h3e, 8'h70);
      for (int i = 0; i < 32; i++) begin
         akb_host_model_i.rd(8'h40 + 8'(i), rb);
         chk("block byte", (i >= 8 && i < 24) ? 8'(128'h0123456789abcdeffedcba9876543210
             >> (8 * (23 - i))) : 8'h00, rb);
         akb_host_model_i.shadow[i] = rb;
      end
      for (int i = 0; i < 16; i++) akb_host_model_i.shadow[8+i] = nkey[127-8*i -: 8];
      cell_mv <= 16'h0aef;
      commit(8'h00, 0);
      cell_mv <= 16'h0af0;
      commit(8'h01, 0);
      commit(8'h00, 1);
      // secret key in place, so the pack is locked again
      pulse(1'b1);
      chk("relocked", 1'b0, unlocked_state);
      akb_host_model_i.wr(8'h61, 8'h01);
      akb_host_model_i.rd(8'h48, rb);
      chk("key after relock", 8'h00, rb);
      akb_host_model_i.wr(8'h61, 8'h00);
      akb_host_model_i.shadow[8] = 8'h77;
      commit(8'h00, 0);
      akb_host_model_i.rd(8'h49, rb);
      chk("locked key byte", 8'h00, rb);
      akb_host_model_i.wr(8'h61, 8'h01);
      run_auth(nkey, 160'hfedcba98765432100123456789abcdef0badcafe);
      complete_run();
   end
endmodule
